// *** src/smsp_edge.v ***
// Purpose: Samples one pin on core_clk and reports its edges as pulses.
// Assumes: The pin is synchronous to core_clk.
// Notes: Edges are reported in the same cycle as the sample that shows them.
`timescale 1ns/1ps
`include "smsp_map.vh"

module smsp_edge #(
    parameter RST_VAL = 1'b0
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Pin in
    input wire sig_in,
    // Sampled level and edge pulses
    output wire level,
    output wire rise,
    output wire fall
);

    reg sample_r;
    reg prev_r;

    // Sample and one-cycle history
    always @(posedge core_clk) begin
        if (rst) begin
            sample_r <= RST_VAL;
            prev_r <= RST_VAL;
        end else begin
            sample_r <= sig_in;
            prev_r <= sample_r;
        end
    end

    assign level = sample_r;
    assign rise = sample_r & ~prev_r;
    assign fall = ~sample_r & prev_r;

endmodule

// *** src/smsp_map.vh ***
// Purpose: Constants shared by the byte-wide SPI master/slave port.
// Assumes: Included by bare name from every design file of the port.
// Notes: Half-period counts are in core_clk cycles, minus one.
`ifndef SMSP_MAP_VH
`define SMSP_MAP_VH

// Bit counter
`define SMSP_CNT_W 3
`define SMSP_CNT_ZERO 3'h0
`define SMSP_CNT_ONE 3'h1
`define SMSP_CNT_LAST 3'h7

// Half SCK period minus one, indexed by {double, rate_high, rate_low}
`define SMSP_DIV_W 6
`define SMSP_DIV_ZERO 6'h00
`define SMSP_DIV_ONE 6'h01
`define SMSP_HALF_M1_SEL0 6'h01
`define SMSP_HALF_M1_SEL1 6'h07
`define SMSP_HALF_M1_SEL2 6'h1f
`define SMSP_HALF_M1_SEL3 6'h3f
`define SMSP_HALF_M1_SEL4 6'h00
`define SMSP_HALF_M1_SEL5 6'h03
`define SMSP_HALF_M1_SEL6 6'h0f
`define SMSP_HALF_M1_SEL7 6'h1f

// Reset values
`define SMSP_BYTE_RST 8'h00

`endif

// *** src/smsp_rate_div.v ***
// Purpose: Master SCK rate divider, one tick per half SCK period.
// Assumes: run is held high for the whole byte and low between bytes.
// Notes: Counter restarts from zero on every run, so the first half period is full.
`timescale 1ns/1ps
`include "smsp_map.vh"

module smsp_rate_div (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Control
    input wire run,
    input wire [2:0] rate_sel,
    // Tick out
    output wire tick
);

    reg [`SMSP_DIV_W-1:0] count_r;
    reg [`SMSP_DIV_W-1:0] half_m1;

    // Rate table: /4 /16 /64 /128, halved by the double-rate bit
    always @* begin
        case (rate_sel)
            3'h0: half_m1 = `SMSP_HALF_M1_SEL0;
            3'h1: half_m1 = `SMSP_HALF_M1_SEL1;
            3'h2: half_m1 = `SMSP_HALF_M1_SEL2;
            3'h3: half_m1 = `SMSP_HALF_M1_SEL3;
            3'h4: half_m1 = `SMSP_HALF_M1_SEL4;
            3'h5: half_m1 = `SMSP_HALF_M1_SEL5;
            3'h6: half_m1 = `SMSP_HALF_M1_SEL6;
            default: half_m1 = `SMSP_HALF_M1_SEL7;
        endcase
    end

    assign tick = run & (count_r == half_m1);

    // Half-period counter, held at zero while idle so the clock truly halts
    always @(posedge core_clk) begin
        if (rst || !run || tick) begin
            count_r <= `SMSP_DIV_ZERO;
        end else begin
            count_r <= count_r + `SMSP_DIV_ONE;
        end
    end

endmodule

// *** src/smsp_top.v ***
// Purpose: Byte-wide full-duplex SPI port acting as master or slave.
// Assumes: All pins and software strobes are synchronous to core_clk (10 MHz).
// Notes: Slave SCK is sampled, so each SCK phase must exceed two core_clk cycles.
`timescale 1ns/1ps
`include "smsp_map.vh"

module smsp_top (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Configuration
    input wire port_enable,
    input wire master_select,
    input wire transfer_irq_enable,
    input wire bit_order_select,
    input wire clock_polarity,
    input wire clock_phase,
    input wire rate_select_high,
    input wire rate_select_low,
    input wire double_rate_select,
    // User pin directions and SS level
    input wire user_mosi_dir,
    input wire user_miso_dir,
    input wire user_sck_dir,
    input wire user_ss_dir,
    input wire user_ss_level,
    // Software access to the shift data register
    input wire data_wr,
    input wire [7:0] data_wdata,
    input wire data_rd,
    input wire status_rd,
    input wire irq_ack,
    // Software view
    output reg [7:0] rx_data_r,
    output reg transfer_done_flag_r,
    output reg write_collision_flag_r,
    output reg master_active_r,
    output reg busy_r,
    output reg irq_r,
    // Serial pins
    input wire sck_in,
    output reg sck_out_r,
    output reg sck_oe_r,
    input wire mosi_in,
    output reg mosi_out_r,
    output reg mosi_oe_r,
    input wire miso_in,
    output reg miso_out_r,
    output reg miso_oe_r,
    input wire ss_n_in,
    output reg ss_n_out_r,
    output reg ss_n_oe_r
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    reg state_r;
    reg state_nxt;
    reg phase_r;
    reg phase_nxt;
    reg [7:0] shift_r;
    reg [7:0] shift_nxt;
    reg [`SMSP_CNT_W-1:0] cnt_r;
    reg [`SMSP_CNT_W-1:0] cnt_nxt;
    reg full_r;
    reg full_nxt;
    reg out_bit_r;
    reg out_bit_nxt;
    reg [7:0] rx_nxt;
    reg fault_r;
    reg armed_r;
    reg done_evt;
    reg write_collision_flag_evt;
    reg [7:0] shifted;

    wire tick;
    wire sck_lvl;
    wire sck_rise;
    wire sck_fall;
    wire ss_lvl;
    wire ss_rise;
    wire master_mode;
    wire slave_mode;
    wire fault_set;
    wire m_sample;
    wire m_setup;
    wire s_active;
    wire s_sample;
    wire s_setup;
    wire sample_ev;
    wire setup_ev;
    wire in_bit;
    wire busy;
    wire flag_clr;
    wire done_nxt;
    wire write_collision_flag_nxt;

    // Master SCK rate source
    smsp_rate_div u_rate (
        .core_clk(core_clk),
        .rst(rst),
        .run(state_r == ST_RUN),
        .rate_sel({double_rate_select, rate_select_high, rate_select_low}),
        .tick(tick)
    );

    // Slave SCK is sampled on core_clk, never used as a clock
    smsp_edge #(.RST_VAL(1'b0)) u_sck (
        .core_clk(core_clk),
        .rst(rst),
        .sig_in(sck_in),
        .level(sck_lvl),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    // Slave select, idles high after reset
    smsp_edge #(.RST_VAL(1'b1)) u_ss (
        .core_clk(core_clk),
        .rst(rst),
        .sig_in(ss_n_in),
        .level(ss_lvl),
        .rise(ss_rise),
        .fall()
    );

    // Mode: an SS input pulled low while master drops the port to slave
    assign master_mode = port_enable & master_select & ~fault_r;
    assign slave_mode = port_enable & ~master_mode;
    assign fault_set = master_mode & ~user_ss_dir & ~ss_lvl;

    // Master edges: ticks with phase_r low are leading; sample where phase matches
    assign m_sample = tick & (phase_r == clock_phase);
    assign m_setup = tick & (phase_r != clock_phase);

    // Slave edges from sampled SCK, only while selected
    assign s_active = slave_mode & ~ss_lvl & ~ss_rise;
    assign s_sample = s_active & ((clock_polarity ^ clock_phase) ? sck_fall : sck_rise);
    assign s_setup = s_active & ((clock_polarity ^ clock_phase) ? sck_rise : sck_fall);

    assign sample_ev = (state_r == ST_RUN) ? m_sample : s_sample;
    assign setup_ev = (state_r == ST_RUN) ? m_setup : s_setup;
    assign in_bit = master_mode ? miso_in : mosi_in;

    // A byte in flight: master running, or slave part way through a byte
    assign busy = (state_r == ST_RUN) | (s_active & (cnt_r != `SMSP_CNT_ZERO));

    // Shift engine; sampling and output update sit on opposite edges
    always @* begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        full_nxt = full_r;
        out_bit_nxt = out_bit_r;
        rx_nxt = rx_data_r;
        done_evt = 1'b0;
        write_collision_flag_evt = 1'b0;
        shifted = bit_order_select ? {in_bit, shift_r[7:1]} : {shift_r[6:0], in_bit};
        if (data_wr && port_enable) begin
            if (busy) begin
                write_collision_flag_evt = 1'b1;
            end else begin
                // Transmit has only the shift register to hold it
                shift_nxt = data_wdata;
                out_bit_nxt = bit_order_select ? data_wdata[0] : data_wdata[7];
                cnt_nxt = `SMSP_CNT_ZERO;
                full_nxt = 1'b0;
                if (master_mode) begin
                    state_nxt = ST_RUN;
                    phase_nxt = 1'b0;
                end
            end
        end
        case (state_r)
            ST_RUN: begin
                if (tick) begin
                    phase_nxt = ~phase_r;
                end
                if (sample_ev) begin
                    shift_nxt = shifted;
                    cnt_nxt = cnt_r + `SMSP_CNT_ONE;
                    if (cnt_r == `SMSP_CNT_LAST) begin
                        full_nxt = 1'b1;
                    end
                end
                if (setup_ev) begin
                    out_bit_nxt = bit_order_select ? shift_r[0] : shift_r[7];
                end
                // Clock stops after the last trailing edge; buffer loads with the flag
                if (tick && phase_r && (full_r || (sample_ev && cnt_r == `SMSP_CNT_LAST))) begin
                    state_nxt = ST_IDLE;
                    done_evt = 1'b1;
                    rx_nxt = shift_nxt;
                end
                // Losing master mode mid-byte abandons the byte
                if (!master_mode) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt = `SMSP_CNT_ZERO;
                end
            end
            ST_IDLE: begin
                if (slave_mode && (ss_lvl || ss_rise)) begin
                    cnt_nxt = `SMSP_CNT_ZERO;
                end else if (slave_mode) begin
                    if (sample_ev) begin
                        shift_nxt = shifted;
                        cnt_nxt = cnt_r + `SMSP_CNT_ONE;
                        if (cnt_r == `SMSP_CNT_LAST) begin
                            rx_nxt = shifted;
                            done_evt = 1'b1;
                        end
                    end
                    if (setup_ev && cnt_r != `SMSP_CNT_ZERO) begin
                        out_bit_nxt = bit_order_select ? shift_r[0] : shift_r[7];
                    end
                end
                // Between bytes the slave presents the first bit of what it holds
                if (slave_mode && cnt_nxt == `SMSP_CNT_ZERO) begin
                    out_bit_nxt = bit_order_select ? shift_nxt[0] : shift_nxt[7];
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Status-then-data clears both flags; a new event in that cycle wins
    assign flag_clr = armed_r & (data_rd | data_wr);
    assign done_nxt = done_evt | fault_set | (transfer_done_flag_r & ~flag_clr & ~irq_ack);
    assign write_collision_flag_nxt = write_collision_flag_evt | (write_collision_flag_r & ~flag_clr);

    // Engine and flag registers
    always @(posedge core_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            phase_r <= 1'b0;
            shift_r <= `SMSP_BYTE_RST;
            cnt_r <= `SMSP_CNT_ZERO;
            full_r <= 1'b0;
            out_bit_r <= 1'b0;
            rx_data_r <= `SMSP_BYTE_RST;
            fault_r <= 1'b0;
            armed_r <= 1'b0;
            transfer_done_flag_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            irq_r <= 1'b0;
            busy_r <= 1'b0;
            master_active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
            out_bit_r <= out_bit_nxt;
            rx_data_r <= rx_nxt;
            // Fault holds until software drops and sets master select again
            fault_r <= fault_set | (fault_r & master_select);
            if (flag_clr) begin
                armed_r <= 1'b0;
            end else if (status_rd && (transfer_done_flag_r || write_collision_flag_r)) begin
                armed_r <= 1'b1;
            end
            transfer_done_flag_r <= done_nxt;
            write_collision_flag_r <= write_collision_flag_nxt;
            irq_r <= done_nxt & transfer_irq_enable;
            busy_r <= (state_nxt == ST_RUN);
            master_active_r <= port_enable & master_select & ~fault_r & ~fault_set;
        end
    end

    // Pin drivers; direction follows the mode, else the user
    always @(posedge core_clk) begin
        if (rst) begin
            sck_out_r <= 1'b0;
            sck_oe_r <= 1'b0;
            mosi_out_r <= 1'b0;
            mosi_oe_r <= 1'b0;
            miso_out_r <= 1'b0;
            miso_oe_r <= 1'b0;
            ss_n_out_r <= 1'b1;
            ss_n_oe_r <= 1'b0;
        end else begin
            // Idle level is the polarity; active half follows the phase flag
            sck_out_r <= clock_polarity ^ ((state_nxt == ST_RUN) & phase_nxt);
            mosi_out_r <= out_bit_nxt;
            miso_out_r <= out_bit_nxt;
            // SS is whatever software asks for, the engine never touches it
            ss_n_out_r <= user_ss_level;
            if (!port_enable) begin
                sck_oe_r <= user_sck_dir;
                mosi_oe_r <= user_mosi_dir;
                miso_oe_r <= user_miso_dir;
                ss_n_oe_r <= user_ss_dir;
            end else if (master_mode && !fault_set) begin
                sck_oe_r <= user_sck_dir;
                mosi_oe_r <= user_mosi_dir;
                miso_oe_r <= 1'b0;
                ss_n_oe_r <= user_ss_dir;
            end else begin
                sck_oe_r <= 1'b0;
                mosi_oe_r <= 1'b0;
                ss_n_oe_r <= 1'b0;
                // Tristated whenever the slave is not selected
                miso_oe_r <= user_miso_dir & ~ss_n_in;
            end
        end
    end

endmodule

// *** testbench/smsp_asserts.sv ***
// Purpose: Port-level checks for the SPI master/slave port.
// Assumes: Bound to smsp_top; one clock domain, synchronous reset.
// Notes: Flag clearing is judged only with the select line high.
`timescale 1ns/1ps
module smsp_asserts (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Software side
    input wire port_enable,
    input wire transfer_irq_enable,
    input wire data_wr,
    input wire data_rd,
    input wire status_rd,
    input wire ss_n_in,
    // Outputs watched
    input wire [7:0] rx_data_r,
    input wire transfer_done_flag_r,
    input wire write_collision_flag_r,
    input wire master_active_r,
    input wire busy_r,
    input wire irq_r,
    input wire miso_oe_r
);
    // Everything here lives on the core clock
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire m_on = port_enable && master_active_r;
    wire any_flag = transfer_done_flag_r || write_collision_flag_r;

    // Byte start, completion and interrupt
    property p_start; m_on && data_wr && !busy_r |=> busy_r; endproperty
    a_start: assert property (p_start) else $error("master write did not start a byte");
    property p_done; $fell(busy_r) && master_active_r |=> transfer_done_flag_r; endproperty
    a_done: assert property (p_done) else $error("byte ended without done flag");
    property p_irq; irq_r == (transfer_done_flag_r && $past(transfer_irq_enable)); endproperty
    a_irq: assert property (p_irq) else $error("interrupt does not follow flag and enable");

    // Collision and the status-then-data clear
    property p_write_collision_flag; m_on && busy_r && data_wr |=> write_collision_flag_r; endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy write did not flag collision");
    property p_clr;
        status_rd && any_flag ##1 data_rd && !busy_r && ss_n_in |=> !any_flag;
    endproperty
    a_clr: assert property (p_clr) else $error("status then data access left a flag set");

    // Pin direction overrides; a lag of up to two cycles is allowed
    property p_slv_z; (port_enable && !master_active_r && ss_n_in)[*3] |-> !miso_oe_r; endproperty
    a_slv_z: assert property (p_slv_z) else $error("deselected slave drives its output");
    property p_mst_in; m_on[*2] |-> !miso_oe_r; endproperty
    a_mst_in: assert property (p_mst_in) else $error("master drives its input pin");

    // Received byte only moves together with a completed transfer
    property p_rx; $changed(rx_data_r) |-> transfer_done_flag_r; endproperty
    a_rx: assert property (p_rx) else $error("receive buffer changed without done flag");
endmodule

bind smsp_top smsp_asserts u_chk (.core_clk(core_clk), .rst(rst), .port_enable(port_enable),
    .transfer_irq_enable(transfer_irq_enable), .data_wr(data_wr), .data_rd(data_rd), .status_rd(status_rd),
    .ss_n_in(ss_n_in), .rx_data_r(rx_data_r), .transfer_done_flag_r(transfer_done_flag_r),
    .write_collision_flag_r(write_collision_flag_r), .master_active_r(master_active_r), .busy_r(busy_r),
    .irq_r(irq_r), .miso_oe_r(miso_oe_r));

// *** testbench/smsp_peer.sv ***
// Purpose: Remote SPI slave facing the port when it acts as master.
// Assumes: Clock and select come from the link; any of the four clock modes.
// Notes: A released output shows the inverse of its last bit, never held data.
`timescale 1ns/1ps
module smsp_peer (
    // Link pins
    input wire sck,
    input wire ss_n,
    input wire mosi,
    output reg miso,
    // Mode and data
    input wire clock_polarity,
    input wire clock_phase,
    input wire [7:0] tx_byte,
    output reg [7:0] rx_byte
);
    reg [2:0] cnt_r;
    initial begin
        miso = 1'b0;
        rx_byte = 8'h00;
        cnt_r = 3'h0;
    end
    // Each select starts a fresh byte with the first bit already out
    always @(negedge ss_n) begin
        cnt_r = 3'h0;
        miso = tx_byte[7];
    end
    // Released line must not look like valid data
    always @(posedge ss_n) miso = ~miso;
    // Sample edge shifts in, the other edge puts the next bit out
    always @(sck) begin
        if (ss_n === 1'b0) begin
            if (sck == ~(clock_polarity ^ clock_phase)) begin
                rx_byte = {rx_byte[6:0], mosi};
                cnt_r = cnt_r + 3'h1;
            end else begin
                miso = tx_byte[3'h7 - cnt_r];
            end
        end
    end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the SPI master/slave port.
// Assumes: Inputs change on the falling edge; the bench is the master in slave tests.
// Notes: Slave SCK phases are four core cycles, safely above the sampling limit.
`timescale 1ns/1ps
module tb_top;
    logic core_clk, rst, port_enable, master_select, transfer_irq_enable, bit_order_select;
    logic clock_polarity, clock_phase, rate_select_high, rate_select_low, double_rate_select;
    logic user_mosi_dir, user_miso_dir, user_sck_dir, user_ss_dir, user_ss_level;
    logic data_wr, data_rd, status_rd, irq_ack, tb_sck, tb_mosi, tb_ss_n;
    logic [7:0] data_wdata, peer_tx, peer_rx, rx_data_r;
    logic done_f, write_collision_flag_f, mact, busy, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
    int failures, comparisons;
    int rate_div[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    // Wire level from whoever drives each pin
    wire sck_w = sck_oe ? sck_o : tb_sck;
    wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire ss_w = ss_oe ? ss_o : tb_ss_n;
    wire peer_miso;
    wire miso_w = miso_oe ? miso_o : peer_miso;

    smsp_top dut (.core_clk(core_clk), .rst(rst), .port_enable(port_enable), .master_select(master_select),
        .transfer_irq_enable(transfer_irq_enable), .bit_order_select(bit_order_select),
        .clock_polarity(clock_polarity), .clock_phase(clock_phase), .rate_select_high(rate_select_high),
        .rate_select_low(rate_select_low), .double_rate_select(double_rate_select),
        .user_mosi_dir(user_mosi_dir), .user_miso_dir(user_miso_dir), .user_sck_dir(user_sck_dir),
        .user_ss_dir(user_ss_dir), .user_ss_level(user_ss_level), .data_wr(data_wr), .data_wdata(data_wdata),
        .data_rd(data_rd), .status_rd(status_rd), .irq_ack(irq_ack), .rx_data_r(rx_data_r),
        .transfer_done_flag_r(done_f), .write_collision_flag_r(write_collision_flag_f), .master_active_r(mact),
        .busy_r(busy), .irq_r(irq), .sck_in(sck_w), .sck_out_r(sck_o), .sck_oe_r(sck_oe), .mosi_in(mosi_w),
        .mosi_out_r(mosi_o), .mosi_oe_r(mosi_oe), .miso_in(miso_w), .miso_out_r(miso_o),
        .miso_oe_r(miso_oe), .ss_n_in(ss_w), .ss_n_out_r(ss_o), .ss_n_oe_r(ss_oe));
    smsp_peer peer (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(peer_miso), .clock_polarity(clock_polarity),
        .clock_phase(clock_phase), .tx_byte(peer_tx), .rx_byte(peer_rx));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction
    task automatic give_verdict;
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait for the done flag, counting cycles from the write edge
    task automatic wait_done(output int took);
        took = 0;
        while (done_f !== 1'b1 && took < 3000) begin
            cyc(1);
            took++;
        end
    endtask
    // Status read with a flag set, then a data access
    task automatic clr;
        status_rd = 1'b1;
        cyc(1);
        status_rd = 1'b0;
        data_rd = 1'b1;
        cyc(1);
        data_rd = 1'b0;
        cyc(1);
        check({6'h0, done_f, write_collision_flag_f}, 8'h00);
    endtask
    // Bench as link master, clock mode 0, MSB first
    task automatic s_byte(input logic [7:0] mo, input int nbits, output logic [7:0] mi);
        mi = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            tb_mosi = mo[7 - i];
            cyc(4);
            mi[7 - i] = miso_w;
            tb_sck = 1'b1;
            cyc(4);
            tb_sck = 1'b0;
        end
        cyc(4);
    endtask

    // Each rate code once, cycling through all four clock modes and both bit orders
    task automatic t_master;
        int took;
        logic [7:0] d;
        for (int s = 0; s < 8; s++) begin
            {double_rate_select, rate_select_high, rate_select_low} = 3'(s);
            {clock_polarity, clock_phase} = 2'(s);
            bit_order_select = s[0];
            d = 8'h5a ^ 8'(s * 37);
            peer_tx = 8'hc3 ^ 8'(s);
            cyc(2);
            check({7'h0, sck_w}, {7'h0, clock_polarity});
            user_ss_level = 1'b0;
            cyc(2);
            data_wdata = d;
            data_wr = 1'b1;
            cyc(1);
            data_wr = 1'b0;
            wait_done(took);
            check({7'h0, took >= 8 * rate_div[s] && took <= 8 * rate_div[s] + 1}, 8'h01);
            user_ss_level = 1'b1;
            cyc(2);
            check(peer_rx, bit_order_select ? rev(d) : d);
            check(rx_data_r, bit_order_select ? rev(peer_tx) : peer_tx);
            check({6'h0, irq, miso_oe}, 8'h02);
            clr;
        end
    endtask

    // Second write while shifting is refused and flagged
    task automatic t_collide;
        int took;
        {double_rate_select, rate_select_high, rate_select_low} = 3'h4;
        {clock_polarity, clock_phase, bit_order_select} = 3'h0;
        transfer_irq_enable = 1'b0;
        user_ss_level = 1'b0;
        cyc(2);
        data_wdata = 8'h81;
        data_wr = 1'b1;
        cyc(1);
        data_wdata = 8'h7e;
        cyc(1);
        data_wr = 1'b0;
        wait_done(took);
        user_ss_level = 1'b1;
        cyc(2);
        check(peer_rx, 8'h81);
        check({7'h0, took == 15}, 8'h01);
        check({6'h0, write_collision_flag_f, irq}, 8'h02);
        irq_ack = 1'b1;
        cyc(1);
        irq_ack = 1'b0;
        cyc(1);
        check({6'h0, done_f, write_collision_flag_f}, 8'h01);
        clr;
        transfer_irq_enable = 1'b1;
    endtask

    // Slave: deselected load, back-to-back bytes, partial byte dropped
    task automatic t_slave;
        logic [7:0] got;
        master_select = 1'b0;
        cyc(3);
        check({4'h0, mact, sck_oe, mosi_oe, miso_oe}, 8'h00);
        data_wdata = 8'hb4;
        data_wr = 1'b1;
        cyc(1);
        data_wr = 1'b0;
        s_byte(8'hff, 8, got);
        check({7'h0, done_f}, 8'h00);
        tb_ss_n = 1'b0;
        cyc(2);
        s_byte(8'h96, 8, got);
        check(got, 8'hb4);
        check(rx_data_r, 8'h96);
        check({6'h0, done_f, irq}, 8'h03);
        data_wdata = 8'h2d;
        data_wr = 1'b1;
        cyc(1);
        data_wr = 1'b0;
        s_byte(8'h71, 8, got);
        check(got, 8'h2d);
        check(rx_data_r, 8'h71);
        s_byte(8'hff, 3, got);
        tb_ss_n = 1'b1;
        cyc(3);
        tb_ss_n = 1'b0;
        cyc(2);
        s_byte(8'h0f, 8, got);
        check(rx_data_r, 8'h0f);
        tb_ss_n = 1'b1;
        cyc(3);
        check({7'h0, miso_oe}, 8'h00);
    endtask

    initial begin
        failures = 0;
        comparisons = 0;
        {rst, port_enable, master_select, transfer_irq_enable, bit_order_select} = 5'h1e;
        {clock_polarity, clock_phase, rate_select_high, rate_select_low, double_rate_select} = 5'h00;
        {user_mosi_dir, user_miso_dir, user_sck_dir, user_ss_dir, user_ss_level} = 5'h1f;
        {data_wr, data_rd, status_rd, irq_ack, tb_sck, tb_mosi, tb_ss_n} = 7'h03;
        data_wdata = 8'h00;
        peer_tx = 8'h00;
        cyc(6);
        rst = 1'b0;
        cyc(2);
        t_master;
        t_collide;
        t_slave;
        give_verdict;
    end

    // Whole run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        give_verdict;
    end
endmodule
